// File: scl_pkg.sv
// constants, field layouts and carrier types for the serial rom config loader
// assumes a single 200 MHz clock domain shared by the loader and its bus slave
package scl_pkg;

	// rom map positions handled by this loader
	localparam logic [7:0] ROM_FIRST = 8'h1A;
	localparam logic [7:0] ROM_RSVD_22 = 8'h22;
	localparam logic [7:0] ROM_CNT_MAIN = 8'h23;
	localparam logic [7:0] ROM_SSVID_LO = 8'h25;
	localparam logic [7:0] ROM_SSVID_HI = 8'h26;
	localparam logic [7:0] ROM_SSID_LO = 8'h27;
	localparam logic [7:0] ROM_SSID_HI = 8'h28;
	localparam logic [7:0] ROM_AUX_PTR = 8'h2A;
	localparam logic [7:0] ROM_CHECKSUM = 8'h33;
	localparam logic [7:0] ROM_MISC0 = 8'h35;
	localparam logic [7:0] ROM_MISC1 = 8'h36;
	localparam logic [7:0] ROM_FM_IND = 8'h3B;
	localparam logic [7:0] ROM_FM_CNT = 8'h3C;
	localparam logic [7:0] ROM_FM_SSVID_LO = 8'h3D;
	localparam logic [7:0] ROM_FM_SSVID_HI = 8'h3E;
	localparam logic [7:0] ROM_FM_SSID_LO = 8'h3F;
	localparam logic [7:0] ROM_FM_SSID_HI = 8'h40;
	localparam logic [7:0] ROM_MCTRL = 8'h41;
	localparam logic [7:0] ROM_EOL = 8'h42;

	// expected marker values
	localparam logic [7:0] EXP_CNT_MAIN = 8'h17;
	localparam logic [7:0] EXP_FM_IND = 8'h03;
	localparam logic [7:0] EXP_FM_CNT = 8'h05;
	localparam logic [7:0] EXP_EOL = 8'h80;
	localparam logic [7:0] AUX_NONE = 8'h00;

	// loadable bit masks
	localparam logic [7:0] MISC0_MASK = 8'h37;
	localparam logic [7:0] MISC1_MASK = 8'h8F;
	localparam logic [7:0] MCTRL_MASK = 8'h7F;

	// register byte offsets on the bus
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SSID = 8'h08;
	localparam logic [7:0] REG_AUX = 8'h0C;
	localparam logic [7:0] REG_MISC = 8'h10;
	localparam logic [7:0] REG_FM_SSID = 8'h14;
	localparam logic [7:0] REG_MCTRL = 8'h18;

	// field positions
	localparam int CTRL_START_BIT = 0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_ECNT_BIT = 2;
	localparam int ST_EIND_BIT = 3;
	localparam int ST_EFCNT_BIT = 4;
	localparam int ST_EEOL_BIT = 5;
	localparam int AUX_PRESENT_BIT = 8;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [15:0] ssvid;
		logic [15:0] ssid;
		logic [7:0] aux_ptr;
		logic [7:0] misc0;
		logic [7:0] misc1;
		logic [15:0] fm_ssvid;
		logic [15:0] fm_ssid;
		logic [7:0] mctrl;
	} scl_cfg_t;

	typedef struct packed {
		logic err_cnt;
		logic err_ind;
		logic err_fcnt;
		logic err_eol;
	} scl_err_t;

	localparam scl_cfg_t CFG_RESET = '0;
	localparam scl_err_t ERR_RESET = '0;

endpackage

// File: scl_loader.sv
// serial rom config loader, tail of the power-up load map, with axi4-lite access
// assumes a byte reader on the same clock: takes an offset by valid/ready, returns one byte later
// Notes on behaviour
// RULE1: byte 23h is main count, expect 17h
// RULE2: bytes 25h-28h load subsystem vendor/subsystem ids
// RULE3: byte 2Ah is aux region pointer, 00h none
// RULE4: checksum byte 33h loads nothing
// RULE5: byte 35h loads misc byte0 bits 5,4,2,1,0
// RULE6: byte 36h loads misc byte1 bits 7,3,2,1,0
// RULE7: byte 3Bh is flash indicator, expect 03h
// RULE8: byte 3Ch is flash count, expect 05h
// RULE9: bytes 3Dh-40h load flash function ids
// RULE10: byte 41h bits 6-0 load control, bit7 kept
// RULE11: stop at end marker 80h, keep values
// RULE12: reserved positions skipped, reading continues
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
module scl_loader (
	input wire logic mclk,
	input wire logic reset_n,
	output logic rom_req_valid,
	input wire logic rom_req_ready,
	output logic [7:0] rom_req_addr,
	input wire logic rom_rsp_valid,
	input wire logic [7:0] rom_rsp_data,
	output scl_pkg::scl_cfg_t cfg_out,
	output logic load_busy,
	output logic load_done,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	typedef enum {
		ST_IDLE,
		ST_REQ,
		ST_WAIT
	} scl_state_t;

	// bus-side state
	logic aw_held_ff, nxt_aw_held;
	logic [7:0] aw_addr_ff, nxt_aw_addr;
	logic w_held_ff, nxt_w_held;
	logic [31:0] w_data_ff, nxt_w_data;
	logic [3:0] w_strb_ff, nxt_w_strb;
	logic bvalid_ff, nxt_bvalid;
	logic [1:0] bresp_ff, nxt_bresp;
	logic rvalid_ff, nxt_rvalid;
	logic [1:0] rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;

	// loader state
	scl_state_t state_ff, nxt_state;
	logic [7:0] addr_ff, nxt_addr;
	logic start_ff, nxt_start;
	logic done_ff, nxt_done;
	scl_pkg::scl_cfg_t cfg_ff, nxt_cfg;
	scl_pkg::scl_err_t err_ff, nxt_err;

	logic wr_fire;
	logic [31:0] reg_rd;

	// true when the byte offset names a mapped register
	function automatic logic reg_mapped(input logic [7:0] a);
		reg_mapped = (a == scl_pkg::REG_CTRL) || (a == scl_pkg::REG_STATUS) || (a == scl_pkg::REG_SSID) ||
			(a == scl_pkg::REG_AUX) || (a == scl_pkg::REG_MISC) || (a == scl_pkg::REG_FM_SSID) ||
			(a == scl_pkg::REG_MCTRL);
	endfunction

	// byte-lane merge for software writes
	function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s,
		input int k);
		lane = s[k] ? d[8*k +: 8] : old;
	endfunction

	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	assign rom_req_valid = (state_ff == ST_REQ);
	assign rom_req_addr = addr_ff;
	assign cfg_out = cfg_ff;
	assign load_busy = (state_ff != ST_IDLE);
	assign load_done = done_ff;

	always_comb begin
		reg_rd = 32'h0000_0000;
		case (s_axi_araddr)
			scl_pkg::REG_STATUS: begin
				reg_rd[scl_pkg::ST_BUSY_BIT] = load_busy;
				reg_rd[scl_pkg::ST_DONE_BIT] = done_ff;
				reg_rd[scl_pkg::ST_ECNT_BIT] = err_ff.err_cnt;
				reg_rd[scl_pkg::ST_EIND_BIT] = err_ff.err_ind;
				reg_rd[scl_pkg::ST_EFCNT_BIT] = err_ff.err_fcnt;
				reg_rd[scl_pkg::ST_EEOL_BIT] = err_ff.err_eol;
			end
			scl_pkg::REG_SSID: reg_rd = {cfg_ff.ssid, cfg_ff.ssvid};
			scl_pkg::REG_AUX: begin
				reg_rd[7:0] = cfg_ff.aux_ptr;
				reg_rd[scl_pkg::AUX_PRESENT_BIT] = (cfg_ff.aux_ptr != scl_pkg::AUX_NONE); // RULE3
			end
			scl_pkg::REG_MISC: reg_rd[15:0] = {cfg_ff.misc1, cfg_ff.misc0};
			scl_pkg::REG_FM_SSID: reg_rd = {cfg_ff.fm_ssid, cfg_ff.fm_ssvid};
			scl_pkg::REG_MCTRL: reg_rd[7:0] = cfg_ff.mctrl;
			default: reg_rd = 32'h0000_0000;
		endcase
	end

	// bus slave: address and data may arrive in either order, response once both are held
	always_comb begin
		nxt_aw_held = aw_held_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_held = w_held_ff;
		nxt_w_data = w_data_ff;
		nxt_w_strb = w_strb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_held = 1'b1;
			nxt_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_held = 1'b1;
			nxt_w_data = s_axi_wdata;
			nxt_w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			nxt_aw_held = 1'b0;
			nxt_w_held = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = reg_mapped(aw_addr_ff) ? scl_pkg::RESP_OKAY : scl_pkg::RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rdata = reg_rd;
			nxt_rresp = reg_mapped(s_axi_araddr) ? scl_pkg::RESP_OKAY : scl_pkg::RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_held_ff <= 1'b0;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= scl_pkg::RESP_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= scl_pkg::RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
		end else begin
			aw_held_ff <= nxt_aw_held;
			aw_addr_ff <= nxt_aw_addr;
			w_held_ff <= nxt_w_held;
			w_data_ff <= nxt_w_data;
			w_strb_ff <= nxt_w_strb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
		end
	end

	// loader walk and configuration fields; a rom byte landing in the same cycle as a
	// software write to the same field wins, so a load is never partly undone
	always_comb begin
		nxt_state = state_ff;
		nxt_addr = addr_ff;
		nxt_start = start_ff;
		nxt_done = done_ff;
		nxt_cfg = cfg_ff;
		nxt_err = err_ff;
		if (wr_fire) begin
			case (aw_addr_ff)
				scl_pkg::REG_CTRL: if (w_strb_ff[0] && w_data_ff[scl_pkg::CTRL_START_BIT]) nxt_start = 1'b1;
				scl_pkg::REG_MISC: begin
					nxt_cfg.misc0 = lane(cfg_ff.misc0, w_data_ff, w_strb_ff, 0);
					nxt_cfg.misc1 = lane(cfg_ff.misc1, w_data_ff, w_strb_ff, 1);
				end
				scl_pkg::REG_MCTRL: nxt_cfg.mctrl = lane(cfg_ff.mctrl, w_data_ff, w_strb_ff, 0);
				default: nxt_cfg = nxt_cfg;
			endcase
		end
		case (state_ff)
			ST_IDLE: begin
				if (start_ff) begin
					// a start written as this load begins is kept for the next load, not lost
					nxt_start = wr_fire && (aw_addr_ff == scl_pkg::REG_CTRL) && w_strb_ff[0] &&
						w_data_ff[scl_pkg::CTRL_START_BIT];
					nxt_done = 1'b0;
					nxt_err = scl_pkg::ERR_RESET;
					nxt_addr = scl_pkg::ROM_FIRST;
					nxt_state = ST_REQ;
				end
			end
			ST_REQ: begin
				if (rom_req_ready) nxt_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (rom_rsp_valid) begin
					case (addr_ff)
						scl_pkg::ROM_CNT_MAIN: nxt_err.err_cnt = (rom_rsp_data != scl_pkg::EXP_CNT_MAIN); // RULE1
						scl_pkg::ROM_SSVID_LO: nxt_cfg.ssvid[7:0] = rom_rsp_data; // RULE2
						scl_pkg::ROM_SSVID_HI: nxt_cfg.ssvid[15:8] = rom_rsp_data; // RULE2
						scl_pkg::ROM_SSID_LO: nxt_cfg.ssid[7:0] = rom_rsp_data; // RULE2
						scl_pkg::ROM_SSID_HI: nxt_cfg.ssid[15:8] = rom_rsp_data; // RULE2
						scl_pkg::ROM_AUX_PTR: nxt_cfg.aux_ptr = rom_rsp_data; // RULE3
						scl_pkg::ROM_MISC0: nxt_cfg.misc0 = (cfg_ff.misc0 & ~scl_pkg::MISC0_MASK) |
							(rom_rsp_data & scl_pkg::MISC0_MASK); // RULE5
						scl_pkg::ROM_MISC1: nxt_cfg.misc1 = (cfg_ff.misc1 & ~scl_pkg::MISC1_MASK) |
							(rom_rsp_data & scl_pkg::MISC1_MASK); // RULE6
						scl_pkg::ROM_FM_IND: nxt_err.err_ind = (rom_rsp_data != scl_pkg::EXP_FM_IND); // RULE7
						scl_pkg::ROM_FM_CNT: nxt_err.err_fcnt = (rom_rsp_data != scl_pkg::EXP_FM_CNT); // RULE8
						scl_pkg::ROM_FM_SSVID_LO: nxt_cfg.fm_ssvid[7:0] = rom_rsp_data; // RULE9
						scl_pkg::ROM_FM_SSVID_HI: nxt_cfg.fm_ssvid[15:8] = rom_rsp_data; // RULE9
						scl_pkg::ROM_FM_SSID_LO: nxt_cfg.fm_ssid[7:0] = rom_rsp_data; // RULE9
						scl_pkg::ROM_FM_SSID_HI: nxt_cfg.fm_ssid[15:8] = rom_rsp_data; // RULE9
						scl_pkg::ROM_MCTRL: nxt_cfg.mctrl = (cfg_ff.mctrl & ~scl_pkg::MCTRL_MASK) |
							(rom_rsp_data & scl_pkg::MCTRL_MASK); // RULE10
						scl_pkg::ROM_EOL: nxt_err.err_eol = (rom_rsp_data != scl_pkg::EXP_EOL); // RULE11
						// checksum, reserved and earlier-map positions fall here and load nothing
						default: nxt_cfg = nxt_cfg; // RULE4 RULE12
					endcase
					if (addr_ff == scl_pkg::ROM_EOL) begin
						// the last position ends the walk even with a bad marker, flagged instead
						nxt_state = ST_IDLE; // RULE11
						nxt_done = 1'b1;
					end else begin
						nxt_addr = addr_ff + 8'h01; // RULE12
						nxt_state = ST_REQ;
					end
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= ST_IDLE;
			addr_ff <= scl_pkg::ROM_FIRST;
			start_ff <= 1'b1;
			done_ff <= 1'b0;
			cfg_ff <= scl_pkg::CFG_RESET;
			err_ff <= scl_pkg::ERR_RESET;
		end else begin
			state_ff <= nxt_state;
			addr_ff <= nxt_addr;
			start_ff <= nxt_start;
			done_ff <= nxt_done;
			cfg_ff <= nxt_cfg;
			err_ff <= nxt_err;
		end
	end

endmodule // scl_loader

// File: scl_monitor.sv
// checker for the loader's rom walk and configuration field loading
// sees only loader ports; one clock domain, bound to every loader instance
module scl_monitor (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic rom_req_valid,
	input wire logic rom_req_ready,
	input wire logic [7:0] rom_req_addr,
	input wire logic rom_rsp_valid,
	input wire logic [7:0] rom_rsp_data,
	input wire scl_pkg::scl_cfg_t cfg_out,
	input wire logic load_busy,
	input wire logic load_done,
	input wire logic s_axi_bvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pend_ff, nxt_pend;
	logic [7:0] last_ff, nxt_last;
	logic hit;
	always_comb begin
		nxt_pend = pend_ff;
		nxt_last = last_ff;
		if (rom_req_valid && rom_req_ready) begin
			nxt_pend = 1'b1;
			nxt_last = rom_req_addr;
		end else if (rom_rsp_valid) begin
			nxt_pend = 1'b0;
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pend_ff <= 1'b0;
			last_ff <= 8'h00;
		end else begin
			pend_ff <= nxt_pend;
			last_ff <= nxt_last;
		end
	end
	// a software write lands on the edge that raises bvalid; only misc and control may change then
	assign hit = pend_ff && rom_rsp_valid;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	ssvid_load_a: assert property (hit && last_ff == 8'h26 |=>
		cfg_out.ssvid[15:8] == $past(rom_rsp_data)) else $error("ssvid high byte not loaded");
	aux_ptr_a: assert property (hit && last_ff == 8'h2A |=>
		cfg_out.aux_ptr == $past(rom_rsp_data)) else $error("aux pointer not loaded");
	checksum_skip_a: assert property (hit && last_ff == 8'h33 |=> $stable(cfg_out) ||
		($rose(s_axi_bvalid) && $stable({cfg_out.ssvid, cfg_out.ssid, cfg_out.aux_ptr, cfg_out.fm_ssvid,
		cfg_out.fm_ssid}))) else $error("checksum byte changed config");
	misc0_bits_a: assert property (hit && last_ff == 8'h35 |=>
		cfg_out.misc0 == (($past(rom_rsp_data) & 8'h37) | ($past(cfg_out.misc0) & 8'hC8)))
		else $error("misc byte 0 load wrong");
	misc1_bits_a: assert property (hit && last_ff == 8'h36 |=>
		cfg_out.misc1 == (($past(rom_rsp_data) & 8'h8F) | ($past(cfg_out.misc1) & 8'h70)))
		else $error("misc byte 1 load wrong");
	fm_ssid_a: assert property (hit && last_ff == 8'h40 |=>
		cfg_out.fm_ssid[15:8] == $past(rom_rsp_data)) else $error("flash ssid high byte not loaded");
	mctrl_bits_a: assert property (hit && last_ff == 8'h41 |=>
		cfg_out.mctrl == (($past(rom_rsp_data) & 8'h7F) | ($past(cfg_out.mctrl) & 8'h80)))
		else $error("control byte load wrong");
	end_of_list_a: assert property (hit && last_ff == 8'h42 |=>
		load_done && !load_busy ##1 !rom_req_valid [*3]) else $error("walk did not stop at end");
	reserved_skip_a: assert property (hit && last_ff inside {8'h22, 8'h29, [8'h2B:8'h32], 8'h34, [8'h37:8'h3A]}
		|=> $stable(cfg_out) || ($rose(s_axi_bvalid) && $stable({cfg_out.ssvid, cfg_out.ssid, cfg_out.aux_ptr,
		cfg_out.fm_ssvid, cfg_out.fm_ssid}))) else $error("reserved byte changed config");
endmodule // scl_monitor

bind scl_loader scl_monitor mon (.mclk, .reset_n, .rom_req_valid, .rom_req_ready, .rom_req_addr,
	.rom_rsp_valid, .rom_rsp_data, .cfg_out, .load_busy, .load_done, .s_axi_bvalid);

// File: scl_rom_model.sv
// behavioural serial rom reader: one byte per accepted request, with an adjustable extra wait
// assumes the loader keeps at most one request outstanding
module scl_rom_model (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [7:0] req_addr,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	input wire logic [3:0] delay
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	logic [7:0] addr;
	logic [3:0] cnt;
	logic busy;
	assign req_ready = reset_n && !busy;
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h5A;
		end else begin
			rsp_valid <= 1'b0;
			// data toggles between answers so a stale byte is never mistaken for a fresh one
			rsp_data <= ~rsp_data;
			if (!busy && req_valid) begin
				busy <= 1'b1;
				addr <= req_addr;
				cnt <= delay;
			end else if (busy && cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (busy) begin
				busy <= 1'b0;
				rsp_valid <= 1'b1;
				rsp_data <= mem[addr];
			end
		end
	end
endmodule // scl_rom_model

// File: testbench.sv
// self-checking bench for the loader: rom model on the byte port, axi4-lite master tasks
// assumes the checker is bound from its own file
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic rom_req_valid, rom_req_ready, rom_rsp_valid, load_busy, load_done;
	logic [7:0] rom_req_addr, rom_rsp_data;
	scl_pkg::scl_cfg_t cfg_out;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [3:0] delay = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int errors = 0;
	int checks_done = 0;
	always #2.5 mclk = ~mclk;
	scl_loader DUT (.mclk, .reset_n, .rom_req_valid, .rom_req_ready, .rom_req_addr, .rom_rsp_valid,
		.rom_rsp_data, .cfg_out, .load_busy, .load_done, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	scl_rom_model rom (.mclk, .reset_n, .req_valid(rom_req_valid), .req_ready(rom_req_ready),
		.req_addr(rom_req_addr), .rsp_valid(rom_rsp_valid), .rsp_data(rom_rsp_data), .delay);
	task automatic end_sim();
		if (errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(inout int n, input int lim);
		@(posedge mclk);
		n++;
		if (n > lim) begin
			errors++;
			end_sim();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			tick(n, 50);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check($sformatf("bresp %h", a), 32'(s_axi_bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			tick(n, 50);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check($sformatf("rdata %h", a), s_axi_rdata, exp);
		check($sformatf("rresp %h", a), 32'(s_axi_rresp), 32'(er));
	endtask
	task automatic fill(input logic [7:0] salt, input logic bad);
		for (int i = 0; i < 256; i++) rom.mem[i] = 8'(i) ^ salt;
		rom.mem[8'h23] = bad ? 8'h16 : 8'h17;
		rom.mem[8'h2A] = bad ? 8'h5A : 8'h00;
		rom.mem[8'h3B] = bad ? 8'h04 : 8'h03;
		rom.mem[8'h3C] = bad ? 8'h06 : 8'h05;
		rom.mem[8'h42] = bad ? 8'h81 : 8'h80;
	endtask
	task automatic wait_done();
		int n;
		n = 0;
		while (!load_busy) tick(n, 2000);
		while (!load_done) tick(n, 2000);
	endtask
	task automatic expect_cfg(input logic [7:0] m0, input logic [7:0] m1, input logic [7:0] mc, input logic [31:0] st);
		rd(scl_pkg::REG_SSID, {rom.mem[8'h28], rom.mem[8'h27], rom.mem[8'h26], rom.mem[8'h25]}, 2'h0);
		rd(scl_pkg::REG_AUX, {23'h0, rom.mem[8'h2A] != 8'h00, rom.mem[8'h2A]}, 2'h0);
		rd(scl_pkg::REG_MISC, {16'h0, m1 & 8'h70 | rom.mem[8'h36] & 8'h8F, m0 & 8'hC8 | rom.mem[8'h35] & 8'h37},
			2'h0);
		rd(scl_pkg::REG_FM_SSID, {rom.mem[8'h40], rom.mem[8'h3F], rom.mem[8'h3E], rom.mem[8'h3D]}, 2'h0);
		rd(scl_pkg::REG_MCTRL, {24'h0, mc & 8'h80 | rom.mem[8'h41] & 8'h7F}, 2'h0);
		rd(scl_pkg::REG_STATUS, st, 2'h0);
	endtask
	task automatic auto_load();
		wait_done();
		check("cfg fm_ssvid", 32'(cfg_out.fm_ssvid), {16'h0, rom.mem[8'h3E], rom.mem[8'h3D]});
		expect_cfg(8'h00, 8'h00, 8'h00, 32'h2);
	endtask
	// software sets every misc and control bit, then a slow rom with bad markers is reloaded
	task automatic reload_kept_bits();
		wr(scl_pkg::REG_MISC, 32'h0000FFFF, 4'h3, 2'h0);
		wr(scl_pkg::REG_MCTRL, 32'h000000FF, 4'h1, 2'h0);
		fill(8'h3C, 1'b1);
		delay <= 4'h3;
		wr(scl_pkg::REG_CTRL, 32'h1, 4'h1, 2'h0);
		rd(scl_pkg::REG_STATUS, 32'h1, 2'h0);
		wait_done();
		expect_cfg(8'hFF, 8'hFF, 8'hFF, 32'h3E);
	endtask
	task automatic bus_refusals();
		rd(8'h1C, 32'h0, scl_pkg::RESP_SLVERR);
		wr(8'h20, 32'hFFFFFFFF, 4'hF, scl_pkg::RESP_SLVERR);
		wr(scl_pkg::REG_MISC, 32'h00001234, 4'h2, 2'h0);
		rd(scl_pkg::REG_MISC, {16'h0, 8'h12, 8'hC8 | rom.mem[8'h35] & 8'h37}, 2'h0);
	endtask
	initial begin
		fill(8'hC3, 1'b0);
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		auto_load();
		reload_kept_bits();
		bus_refusals();
		end_sim();
	end
endmodule // testbench
